// >>> verilog/serial_rx_pkg.sv
// package: register map, field positions and state types of the serial port block
//Behaviour
//(RQ1) tx inserts parity after data, before stop
//(RQ2) tx disable waits for shifter and buffer empty
//(RQ3) disabled tx releases serial output pin
//(RQ4) rx enable takes over serial input pin
//(RQ5) sync mode samples on transfer clock pin
//(RQ6) shift bits to first stop, ignore second
//(RQ7) first stop moves frame into receive buffer
//(RQ8) unused upper data bits read zero
//(RQ9) ninth bit and error flags stored per frame
//(RQ10) data read advances receive fifo
//(RQ11) receive complete flag means unread data
//(RQ12) rx disable flushes buffer, clears flag
//(RQ13) irq requested while enable and flag set
//(RQ14) error flags ignore software writes
//(RQ15) error flags raise no interrupt
//(RQ16) software writes zero to error flags
//(RQ17) frame error follows first stop bit only
//(RQ18) overrun on start with buffer and shifter full
//(RQ19) overrun clears on successful transfer
//(RQ20) rx parity checked, odd/even by type bit
//(RQ21) parity error per frame, valid until read
//(RQ22) parity disabled reads parity error zero
//(RQ23) software reads status before data
//(RQ24) type bit zero even, one odd
//(RQ25) reset: fifo empty, flags zero, rx/tx off
package serial_rx_pkg;
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_FMT    = 8'h0c;
  localparam logic [7:0] ADDR_BAUD   = 8'h10;

  localparam int STAT_RXC  = 7;
  localparam int STAT_UDRE = 5;
  localparam int STAT_FE   = 4;
  localparam int STAT_DOR  = 3;
  localparam int STAT_UPE  = 2;

  localparam int CTL_RXCIE = 7;
  localparam int CTL_RXEN  = 4;
  localparam int CTL_TRANSMITTER_ENABLE  = 3;
  localparam int CTL_SZ2   = 2;
  localparam int CTL_RXB8  = 1;
  localparam int CTL_TXB8  = 0;

  localparam int FMT_SYNC  = 6;
  localparam int FMT_PEN   = 5;
  localparam int FMT_PTYPE = 4;
  localparam int FMT_STOP2 = 3;
  localparam int FMT_SZ_HI = 2;
  localparam int FMT_SZ_LO = 1;

  localparam int         BAUD_W    = 12;
  localparam logic [2:0] SZ_NINE   = 3'h7;
  localparam logic [3:0] BITS_BASE = 4'h5;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [1:0] FIFO_FULL = 2'h2;

  typedef enum logic [2:0] {
    R_IDLE  = 3'b000,
    R_START = 3'b001,
    R_DATA  = 3'b010,
    R_PAR   = 3'b011,
    R_STOP  = 3'b100
  } rx_state_e;

  typedef enum logic [2:0] {
    T_IDLE  = 3'b000,
    T_START = 3'b001,
    T_DATA  = 3'b010,
    T_PAR   = 3'b011,
    T_STOP1 = 3'b100,
    T_STOP2 = 3'b101
  } tx_state_e;

  typedef struct packed {
    logic       fe;
    logic       dor;
    logic       upe;
    logic [8:0] data;
  } rx_entry_s;

  typedef struct packed {
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
    logic                rxcie;
    logic                rxen;
    logic                transmitter_enable_sw;
    logic                transmitter_enable_eff;
    logic                txb8;
    logic                sync;
    logic                pen;
    logic                ptype;
    logic                stop2;
    logic [2:0]          csize;
    logic [BAUD_W-1:0]   baud;
    rx_state_e           rst;
    logic [BAUD_W-1:0]   rcnt;
    logic [3:0]          ridx;
    logic [8:0]          rsh;
    logic                rpar;
    logic                rprev;
    logic                xprev;
    logic                hold_v;
    rx_entry_s           hold;
    logic                dor_pend;
    rx_entry_s [1:0]     fifo;
    logic [1:0]          count;
    tx_state_e           tst;
    logic [BAUD_W-1:0]   tcnt;
    logic [3:0]          tidx;
    logic [8:0]          tsh;
    logic                tbuf_v;
    logic [8:0]          tbuf;
    logic                txd;
    logic                rx_irq;
  } core_s;
endpackage : serial_rx_pkg

// >>> verilog/serial_rx_parity_tx_disable.sv
// serial port receiver with fifo, tx parity insertion and deferred tx disable, apb slave
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module serial_rx_parity_tx_disable
  import serial_rx_pkg::*;
#(
  parameter logic [BAUD_W-1:0] BAUD_RST = 12'h000f
)
(
  input  wire logic        pclk,              // system clock
  input  wire logic        presetn,           // async reset, active low
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb access phase
  input  wire logic        pwrite,            // apb direction
  input  wire logic [7:0]  paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic      [31:0] prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error, unmapped address
  input  wire logic        serial_in_pin,     // receive line
  input  wire logic        transfer_clock_pin, // external transfer clock
  output logic             serial_out_pin,    // transmit line
  output logic             tx_pin_override,   // tx owns the output pin
  output logic             rx_pin_override,   // rx owns the input pin
  output logic             rx_irq             // receive complete request
);

  core_s q;
  core_s n;

  // reserved size codes alias onto the 5 to 7 bit widths
  function automatic logic [3:0] char_bits(input logic [2:0] sz);
    return (sz == SZ_NINE) ? BITS_NINE : 4'(BITS_BASE + {2'b00, sz[1:0]});
  endfunction : char_bits

  // odd selects inverted parity so the frame carries an odd count of ones
  function automatic logic par_of(input logic [8:0] d, input logic [3:0] nb,
                                  input logic odd);
    logic p;
    p = odd; // RQ24
    for (int i = 0; i < 9; i++)
    begin
      if (4'(i) < nb)
        p = p ^ d[i];
    end
    return p;
  endfunction : par_of

  function automatic logic mapped(input logic [7:0] a);
    return (a == ADDR_DATA) || (a == ADDR_STATUS) || (a == ADDR_CTRL) ||
           (a == ADDR_FMT) || (a == ADDR_BAUD);
  endfunction : mapped

  // a start while the fifo stays full and a frame already waits loses the held frame
  function automatic logic overrun_hit(input logic [1:0] cnt, input logic held);
    return (cnt == FIFO_FULL) && held;
  endfunction : overrun_hit

  logic       acc;
  logic [3:0] nbits;
  logic       rstrobe;
  logic       tstrobe;
  logic       xrise;
  rx_entry_s  ent;
  logic [31:0] rd;

  always_comb
  begin
    n       = q;
    acc     = psel && penable;
    nbits   = char_bits(q.csize);
    // transfer clock is sampled on pclk, so it must run well below pclk/2
    xrise   = transfer_clock_pin && !q.xprev;
    // in sync mode both directions step on the same transfer clock edge
    rstrobe = q.sync ? xrise : (q.rcnt == '0); // RQ5
    tstrobe = q.sync ? xrise : (q.tcnt == '0);
    ent     = '0;
    rd      = '0;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    n.rprev   = serial_in_pin;
    n.xprev   = transfer_clock_pin;

    // read value captured one cycle before completion
    unique case (paddr)
      ADDR_DATA:
        rd[7:0] = q.fifo[0].data[7:0]; // RQ8
      ADDR_STATUS:
      begin
        rd[STAT_RXC]  = (q.count != '0); // RQ11
        rd[STAT_UDRE] = !q.tbuf_v;
        rd[STAT_FE]   = q.fifo[0].fe; // RQ17
        rd[STAT_DOR]  = q.fifo[0].dor;
        rd[STAT_UPE]  = q.fifo[0].upe && q.pen; // RQ21 RQ22
      end
      ADDR_CTRL:
      begin
        rd[CTL_RXCIE] = q.rxcie;
        rd[CTL_RXEN]  = q.rxen;
        rd[CTL_TRANSMITTER_ENABLE]  = q.transmitter_enable_sw;
        rd[CTL_SZ2]   = q.csize[2];
        rd[CTL_RXB8]  = q.fifo[0].data[8]; // RQ9
        rd[CTL_TXB8]  = q.txb8;
      end
      ADDR_FMT:
      begin
        rd[FMT_SYNC]  = q.sync;
        rd[FMT_PEN]   = q.pen;
        rd[FMT_PTYPE] = q.ptype;
        rd[FMT_STOP2] = q.stop2;
        rd[FMT_SZ_HI] = q.csize[1];
        rd[FMT_SZ_LO] = q.csize[0];
      end
      ADDR_BAUD:
        rd[BAUD_W-1:0] = q.baud;
      default:
        rd = '0;
    endcase

    if (acc && !q.pready)
    begin
      n.pready  = 1'b1;
      // unmapped offsets answer with an error and zero data
      n.pslverr = !mapped(paddr);
      n.prdata  = rd;
    end

    // effects at the completing edge; status writes are dropped
    if (acc && q.pready && pwrite)
    begin
      unique case (paddr)
        ADDR_DATA:
        begin
          // writes with no room or no transmitter are dropped, not queued
          if (q.transmitter_enable_eff && !q.tbuf_v)
          begin
            n.tbuf   = {q.txb8, pwdata[7:0]};
            n.tbuf_v = 1'b1;
          end
        end
        ADDR_CTRL:
        begin
          n.rxcie    = pwdata[CTL_RXCIE];
          n.rxen     = pwdata[CTL_RXEN];
          n.transmitter_enable_sw  = pwdata[CTL_TRANSMITTER_ENABLE];
          n.csize[2] = pwdata[CTL_SZ2];
          n.txb8     = pwdata[CTL_TXB8];
          if (pwdata[CTL_TRANSMITTER_ENABLE])
            n.transmitter_enable_eff = 1'b1;
        end
        ADDR_FMT:
        begin
          n.sync     = pwdata[FMT_SYNC];
          n.pen      = pwdata[FMT_PEN];
          n.ptype    = pwdata[FMT_PTYPE];
          n.stop2    = pwdata[FMT_STOP2];
          n.csize[1] = pwdata[FMT_SZ_HI];
          n.csize[0] = pwdata[FMT_SZ_LO];
        end
        ADDR_BAUD:
          n.baud = pwdata[BAUD_W-1:0];
        default:
          n.baud = n.baud; // RQ14
      endcase
    end

    // fifo pop on data read
    if (acc && q.pready && !pwrite && (paddr == ADDR_DATA) && (q.count != '0))
    begin
      n.fifo[0] = q.fifo[1]; // RQ10
      n.count   = 2'(q.count - 2'h1);
    end

    // receiver
    if (!rstrobe)
      n.rcnt = 12'(q.rcnt - 12'h001);
    else
      n.rcnt = q.baud;
    unique case (q.rst)
      R_IDLE:
      begin
        if (!q.sync && q.rprev && !serial_in_pin)
        begin
          n.rst  = R_START;
          // first look lands half a bit in, near the middle of start
          n.rcnt = q.baud >> 1;
        end
        else if (q.sync && rstrobe && !serial_in_pin)
        begin
          n.rst = R_DATA;
          n.ridx = '0;
          n.rsh  = '0;
          // judged after this cycle's pop so a freed slot is not taken as overrun
          if (overrun_hit(n.count, q.hold_v))
            n.dor_pend = 1'b1; // RQ18
        end
      end

      R_START:
      begin
        if (rstrobe)
        begin
          // high at mid start: a glitch, not a frame
          if (serial_in_pin)
            n.rst = R_IDLE;
          else
          begin
            n.rst  = R_DATA;
            n.ridx = '0;
            n.rsh  = '0; // RQ8
            if (overrun_hit(n.count, q.hold_v))
              n.dor_pend = 1'b1; // RQ18
          end
        end
      end

      R_DATA:
      begin
        if (rstrobe)
        begin
          n.rsh[q.ridx] = serial_in_pin; // RQ6
          n.ridx        = 4'(q.ridx + 4'h1);
          if (4'(q.ridx + 4'h1) == nbits)
            n.rst = q.pen ? R_PAR : R_STOP;
        end
      end

      R_PAR:
      begin
        if (rstrobe)
        begin
          n.rpar = serial_in_pin;
          n.rst  = R_STOP;
        end
      end

      R_STOP:
      begin
        if (rstrobe)
        begin
          // only the first stop bit is looked at; idle waits out a second one
          ent.fe   = !serial_in_pin; // RQ17 RQ6
          ent.upe  = q.pen && (q.rpar != par_of(q.rsh, nbits, q.ptype)); // RQ20 RQ21
          ent.data = q.rsh; // RQ9
          // a newer frame overwrites a waiting one; that is the frame overrun loses
          n.hold   = ent; // RQ7
          n.hold_v = 1'b1;
          n.rst    = R_IDLE;
        end
      end

      default:
        n.rst = R_IDLE;
    endcase

    // a held frame moves in as soon as there is room
    if (n.hold_v && (n.count != FIFO_FULL))
    begin
      n.fifo[n.count[0]]     = n.hold; // RQ7
      n.fifo[n.count[0]].dor = n.dor_pend;
      n.dor_pend             = 1'b0; // RQ19
      n.hold_v               = 1'b0;
      n.count                = 2'(n.count + 2'h1);
    end

    // disabling is immediate: a frame in flight is dropped along with the fifo
    if (!n.rxen)
    begin
      n.count    = '0; // RQ12
      n.hold_v   = 1'b0;
      n.dor_pend = 1'b0;
      n.rst      = R_IDLE;
    end

    // transmitter
    if (!tstrobe)
      n.tcnt = 12'(q.tcnt - 12'h001);
    else
      n.tcnt = q.baud;
    unique case (q.tst)
      T_IDLE:
      begin
        n.txd = 1'b1;
        // a frame already buffered still goes out after the enable is cleared
        if (q.tbuf_v && q.transmitter_enable_eff)
        begin
          n.tsh    = q.tbuf;
          n.tbuf_v = 1'b0;
          n.tidx   = '0;
          n.tcnt   = q.baud;
          n.txd    = 1'b0;
          n.tst    = T_START;
        end
      end

      T_START:
      begin
        if (tstrobe)
        begin
          n.txd = q.tsh[0];
          n.tst = T_DATA;
        end
      end

      T_DATA:
      begin
        if (tstrobe)
        begin
          n.tidx = 4'(q.tidx + 4'h1);
          if (4'(q.tidx + 4'h1) == nbits)
          begin
            n.tst = q.pen ? T_PAR : T_STOP1;
            n.txd = q.pen ? par_of(q.tsh, nbits, q.ptype) : 1'b1; // RQ1
          end
          else
            n.txd = q.tsh[4'(q.tidx + 4'h1)];
        end
      end

      T_PAR:
      begin
        if (tstrobe)
        begin
          n.txd = 1'b1;
          n.tst = T_STOP1;
        end
      end

      T_STOP1:
      begin
        if (tstrobe)
          // a second stop only lengthens the gap before the next start
          n.tst = q.stop2 ? T_STOP2 : T_IDLE;
      end

      T_STOP2:
      begin
        if (tstrobe)
          n.tst = T_IDLE;
      end

      default:
        n.tst = T_IDLE;
    endcase

    // clearing the enable is only a request; the pin stays owned until all is sent
    if (!n.transmitter_enable_sw && (n.tst == T_IDLE) && !n.tbuf_v)
      n.transmitter_enable_eff = 1'b0; // RQ2

    // error flags never feed the request
    n.rx_irq = n.rxcie && (n.count != '0); // RQ13 RQ15
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q      <= '0; // RQ25
      // line idles high; the divisor starts at its default rate
      q.txd  <= 1'b1;
      q.baud <= BAUD_RST;
    end
    else
      q <= n;
  end

  assign prdata          = q.prdata;
  assign pready          = q.pready;
  assign pslverr         = q.pslverr;
  assign serial_out_pin  = q.txd;
  assign tx_pin_override = q.transmitter_enable_eff; // RQ3
  assign rx_pin_override = q.rxen; // RQ4
  assign rx_irq          = q.rx_irq;

endmodule : serial_rx_parity_tx_disable

// >>> verif/serial_rx_properties.sv
// checker: bus handshake, pin ownership and request relations of the serial block
`timescale 1ns/1ps
module serial_rx_properties
  import serial_rx_pkg::*;
(
  input wire logic        pclk,               // clock
  input wire logic        presetn,            // reset
  input wire logic        psel,               // select
  input wire logic        penable,            // access
  input wire logic        pwrite,             // direction
  input wire logic [7:0]  paddr,              // address
  input wire logic [31:0] pwdata,             // write data
  input wire logic [31:0] prdata,             // read data
  input wire logic        pready,             // ready
  input wire logic        pslverr,            // error
  input wire logic        serial_in_pin,      // rx line
  input wire logic        transfer_clock_pin, // xfer clock
  input wire logic        serial_out_pin,     // tx line
  input wire logic        tx_pin_override,    // tx owns pin
  input wire logic        rx_pin_override,    // rx owns pin
  input wire logic        rx_irq              // rx request
);
  logic ctl_wr;
  assign ctl_wr = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  a_ready_one_wait: assert property (s_setup ##1 s_wait |=> pready)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without ready or with data");
  a_rx_own_write: assert property ($changed(rx_pin_override) |-> $past(ctl_wr))
    else $error("rx ownership changed without control write");
  a_tx_own_write: assert property ($rose(tx_pin_override) |-> $past(ctl_wr))
    else $error("tx ownership taken without control write");
  a_tx_release_idle: assert property ($fell(tx_pin_override) |-> serial_out_pin)
    else $error("tx released in mid frame");
  a_tx_pin_owned: assert property (!serial_out_pin |-> tx_pin_override)
    else $error("tx line low while released");
  a_irq_flushed: assert property (!rx_pin_override [*2] |-> !rx_irq)
    else $error("request while receiver off");
endmodule : serial_rx_properties

bind serial_rx_parity_tx_disable serial_rx_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
  .transfer_clock_pin(transfer_clock_pin), .serial_out_pin(serial_out_pin),
  .tx_pin_override(tx_pin_override), .rx_pin_override(rx_pin_override),
  .rx_irq(rx_irq)
);

// >>> verif/remote_tx.sv
// partner: remote transmitter driving the receive line frame by frame
`timescale 1ns/1ps
module remote_tx #(
  parameter int PER = 4
)
(
  input  wire logic pclk, // system clock
  output logic      line  // receive line
);
  initial line = 1'b1;
  task automatic put(input logic v);
    line <= v;
    repeat (PER) @(posedge pclk);
  endtask : put
  task automatic send(input logic [8:0] d, input int n, input logic pen,
                      input logic odd, input logic badp, input logic bads);
    @(posedge pclk);
    put(1'b0);
    for (int i = 0; i < n; i++) put(d[i]);
    if (pen) put(^(d & ((9'h001 << n) - 9'h001)) ^ odd ^ badp);
    put(~bads);
    // idle gap so a frame after a bad stop still starts on a falling edge
    put(1'b1);
  endtask : send
endmodule : remote_tx

// >>> verif/tb_top.sv
// testbench: bus master, random receive frames, tx parity and deferred disable
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top
  import serial_rx_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, sin, xck, e;
  logic        sout, txo, rxo, irq, pready, pslverr, pen, odd;
  logic [7:0]  paddr, mk;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  sz;
  logic [8:0]  d [4];
  logic [3:0]  bp, bs;
  int          n, seed, num_errors, cmp_count;
  always #50 pclk = ~pclk;
  serial_rx_parity_tx_disable u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(sin),
    .transfer_clock_pin(xck), .serial_out_pin(sout), .tx_pin_override(txo),
    .rx_pin_override(rxo), .rx_irq(irq)
  );
  remote_tx u_rtx (.pclk(pclk), .line(sin));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // expected line levels of one 8-bit parity frame, start bit first
  function automatic logic [10:0] tx_frame(input logic [7:0] v, input logic od);
    return {1'b1, ^v ^ od, v, 1'b0};
  endfunction : tx_frame
  task automatic grab(input logic od);
    logic [10:0] b;
    int k;
    for (int f = 0; f < 2; f++)
    begin
      k = 0;
      while (sout !== 1'b0 && k < 99)
      begin
        @(posedge pclk);
        k++;
      end
      for (int i = 0; i < 11; i++)
      begin
        repeat (i ? 4 : 1) @(posedge pclk);
        b[i] = sout;
      end
      `CHK(b, tx_frame(d[f][7:0], od))
      `CHK(txo, 1'b1)
    end
  endtask : grab
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial
  begin
    #(100 * 40000);
    num_errors++;
    final_report();
  end
  initial
  begin
    seed = 32'h0000_dd0d;
    {pclk, presetn, psel, penable, pwrite, xck, num_errors, cmp_count} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_STATUS, 0);
    `CHK({r[7], r[4:2], txo, rxo, sout}, 7'h01)
    apb(0, 8'h14, 0);
    `CHK({e, r}, 33'h0_0000_0000 | 33'h1_0000_0000)
    apb(1, ADDR_BAUD, 3);
    for (int k = 0; k < 8; k++)
    begin
      n = (k == 0) ? 9 : 5 + {$random(seed)} % 5;
      pen = $random(seed);
      odd = $random(seed);
      sz = (n == 9) ? SZ_NINE : 3'(n - 5);
      mk = (n > 8) ? 8'hff : 8'hff >> (8 - n);
      apb(1, ADDR_FMT, {pen, odd, k[0], sz[1:0], 1'b0});
      apb(1, ADDR_CTRL, {sz[2], 2'b00} | 8'h90);
      for (int j = 0; j < 2; j++)
      begin
        d[j] = $random(seed);
        bp[j] = $random(seed);
        bs[j] = ({$random(seed)} % 3) == 0;
        u_rtx.send(d[j], n, pen, odd, bp[j], bs[j]);
      end
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b1)
      for (int j = 0; j < 2; j++)
      begin
        apb(1, ADDR_STATUS, 0);
        apb(0, ADDR_STATUS, 0);
        `CHK({r[7], r[4:2]}, {1'b1, bs[j], 1'b0, pen & bp[j]})
        apb(0, ADDR_CTRL, 0);
        if (n == 9) `CHK(r[1], d[j][8])
        apb(0, ADDR_DATA, 0);
        `CHK(r, {24'h0, d[j][7:0] & mk})
      end
      apb(0, ADDR_STATUS, 0);
      `CHK(r[7], 1'b0)
    end
    apb(1, ADDR_FMT, 8'h06);
    apb(1, ADDR_CTRL, 8'h90);
    // frames 0,1 fill the fifo, 2 waits, 3 starts while full and replaces 2
    for (int j = 0; j < 4; j++)
    begin
      d[j] = $random(seed);
      u_rtx.send(d[j], 8, 0, 0, 0, 0);
    end
    for (int i = 0; i < 3; i++)
    begin
      apb(0, ADDR_STATUS, 0);
      `CHK(r[3], (i == 2))
      apb(0, ADDR_DATA, 0);
      `CHK(r[7:0], d[(i == 2) ? 3 : i][7:0])
    end
    d[0] = $random(seed);
    u_rtx.send(d[0], 8, 0, 0, 0, 0);
    apb(0, ADDR_STATUS, 0);
    `CHK(r[3], 1'b0)
    apb(0, ADDR_DATA, 0);
    `CHK(r[7:0], d[0][7:0])
    // sync mode: the bench's transfer clock rises mid bit, once per four cycles
    apb(1, ADDR_FMT, 8'h46);
    d[1] = $random(seed);
    fork
      u_rtx.send(d[1], 8, 0, 0, 0, 0);
      for (int c = 0; c < 45; c++)
      begin
        @(posedge pclk);
        xck <= c[1];
      end
    join
    apb(0, ADDR_DATA, 0);
    `CHK(r[7:0], d[1][7:0])
    apb(1, ADDR_FMT, 8'h06);
    apb(1, ADDR_CTRL, 8'h10);
    u_rtx.send(9'h05a, 8, 0, 0, 0, 0);
    `CHK({irq, rxo}, 2'b01)
    apb(1, ADDR_CTRL, 8'h80);
    apb(0, ADDR_STATUS, 0);
    `CHK({r[7], irq, rxo}, 3'b000)
    for (int p = 0; p < 2; p++)
    begin
      apb(1, ADDR_FMT, {p[0], 4'h6} | 8'h20);
      apb(1, ADDR_CTRL, 8'h08);
      d[0] = $random(seed);
      d[1] = $random(seed);
      fork
        grab(p[0]);
        begin
          apb(1, ADDR_DATA, {23'h0, d[0]});
          apb(0, ADDR_STATUS, 0);
          apb(1, ADDR_DATA, {23'h0, d[1]});
          apb(1, ADDR_CTRL, 0);
        end
      join
      repeat (6) @(posedge pclk);
      `CHK({txo, sout}, 2'b01)
    end
    final_report();
  end
endmodule : tb_top
